//--- core/dm_cfg.svh
`ifndef DM_CFG_SVH
`define DM_CFG_SVH
// ==========================================
// register map
`define DM_ADDR_W 4
`define DM_CFG_ADDR 4'h0
`define DM_CMD_ADDR 4'h4
`define DM_STAT_ADDR 4'h8
`define DM_CFG_RST 12'h000
// ==========================================
// config fields
`define DM_F_OP 0
`define DM_F_WID 2
`define DM_F_IN_REG 4
`define DM_F_PIPE_REG 5
`define DM_F_OUT_REG 6
`define DM_F_DYN 7
`define DM_F_SX 8
`define DM_F_SY 9
`define DM_F_SUB 10
`define DM_F_SHIFT 11
`define DM_F_CLR 0
// ==========================================
// datapath sizes
`define DM_W9 9
`define DM_W18 18
`define DM_W36 36
`define DM_OPW 72
`define DM_RESW 144
`define DM_LANES 8
`define DM_ACCS 2
// ==========================================
// elements per block
`define DM_N_MUL9 8
`define DM_N_MUL18 4
`define DM_N_MUL36 1
`define DM_N_MAC9 2
`define DM_N_MAC18 2
`define DM_N_ADD9 4
`define DM_N_ADD18 2
`define DM_N_SUM9 2
`define DM_N_SUM18 1
`endif

//--- core/dm_pkg.sv
package dm_pkg;
   typedef enum logic [1:0] {
      dm_plain_multiply_op,
      dm_multiply_accumulate_op,
      dm_dual_product_addsub_op,
      dm_dual_product_addsub_accumulate_op
   } dm_op_t;
   typedef enum logic [1:0] {dm_x9, dm_x18, dm_x36} dm_width_t;
   typedef logic [7:0][71:0] dm_lanes_t;
endpackage : dm_pkg

//--- core/dm_slice.sv
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "dm_cfg.svh"
module dm_slice
   import dm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [`DM_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic in_valid,
   input wire logic [`DM_OPW-1:0] operand_x,
   input wire logic [`DM_OPW-1:0] operand_y,
   input wire logic sign_x,
   input wire logic sign_y,
   input wire logic sub_sel,
   input wire logic shift_load,
   output logic [`DM_RESW-1:0] result,
   output logic result_valid
);
   // ==========================================
   // helpers
   function automatic int dm_wbits(input dm_width_t w);
      case (w)
         dm_x9: return `DM_W9;
         dm_x18: return `DM_W18;
         default: return `DM_W36;
      endcase
   endfunction : dm_wbits

   function automatic int dm_count(input dm_op_t op, input dm_width_t w);
      case (op)
         dm_multiply_accumulate_op: return (w == dm_x9) ? `DM_N_MAC9 : `DM_N_MAC18;
         dm_dual_product_addsub_op: return (w == dm_x9) ? `DM_N_ADD9 : `DM_N_ADD18;
         dm_dual_product_addsub_accumulate_op:
            return (w == dm_x9) ? `DM_N_SUM9 : `DM_N_SUM18;
         default: return (w == dm_x9) ? `DM_N_MUL9 : (w == dm_x18) ? `DM_N_MUL18
            : `DM_N_MUL36;
      endcase
   endfunction : dm_count

   // sign or zero extension of a w-bit operand to the full lane
   function automatic logic [71:0] dm_ext(input logic [71:0] a, input int w,
         input logic sgn);
      logic [71:0] r;
      r = '0;
      for (int i = 0; i < 72; i++) begin
         r[i] = (i < w) ? a[i] : (sgn & a[w-1]);
      end
      return r;
   endfunction : dm_ext

   function automatic logic [71:0] dm_mul(input logic [71:0] a, input logic [71:0] b,
         input int w, input logic sa, input logic sb);
      logic [143:0] full;
      full = dm_ext(a, w, sa) * dm_ext(b, w, sb);
      return full[71:0];
   endfunction : dm_mul

   // element e lands in slot e; slot size follows the element count
   function automatic logic [143:0] dm_pack(input dm_lanes_t v, input int n);
      logic [143:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         if (n == 8) begin
            r[i*18 +: 18] = v[i][17:0];
         end else if (n == 4 && i < 4) begin
            r[i*36 +: 36] = v[i][35:0];
         end else if (n < 4 && i < n) begin
            r[i*72 +: 72] = v[i];
         end
      end
      return r;
   endfunction : dm_pack

   // ==========================================
   // register bus
   logic [11:0] cfg, next_cfg;
   logic clr, next_clr;
   logic [31:0] next_rdata;
   dm_op_t op;
   dm_width_t wid;
   int wb, cnt;

   always_comb begin
      next_cfg = cfg;
      next_clr = 1'b0;
      next_rdata = 32'h0000_0000;
      if (reg_wr && reg_addr == `DM_CFG_ADDR) begin
         next_cfg = reg_wdata[11:0];
      end
      if (reg_wr && reg_addr == `DM_CMD_ADDR) begin
         next_clr = reg_wdata[`DM_F_CLR];
      end
      if (reg_rd) begin
         case (reg_addr)
            `DM_CFG_ADDR: next_rdata = {20'h0_0000, cfg};
            `DM_STAT_ADDR: next_rdata = {24'h00_0000, 4'(cnt), 3'h0, result_valid};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= `DM_CFG_RST;
         clr <= 1'b0;
         reg_rdata <= 32'h0000_0000;
      end else begin
         cfg <= next_cfg;
         clr <= next_clr;
         reg_rdata <= next_rdata;
      end
   end

   // 36-bit width offers only plain multiply
   assign wid = (cfg[`DM_F_WID +: 2] == 2'h3) ? dm_x36 : dm_width_t'(cfg[`DM_F_WID +: 2]);
   assign op = (wid == dm_x36) ? dm_plain_multiply_op : dm_op_t'(cfg[`DM_F_OP +: 2]);
   assign wb = dm_wbits(wid);
   assign cnt = dm_count(op, wid);

   // ==========================================
   // stage 1: input operand registers
   logic [71:0] x_r, y_r, next_x, next_y, x1, y1;
   logic sx_r, sy_r, sub_r, v_r, next_sx, next_sy, next_sub, sx1, sy1, sub1, v1;
   logic dyn, shift_c;

   always_comb begin
      dyn = cfg[`DM_F_DYN];
      shift_c = dyn ? shift_load : cfg[`DM_F_SHIFT];
      next_sx = dyn ? sign_x : cfg[`DM_F_SX];
      next_sy = dyn ? sign_y : cfg[`DM_F_SY];
      next_sub = dyn ? sub_sel : cfg[`DM_F_SUB];
      next_x = operand_x;
      next_y = operand_y;
      if (shift_c) begin
         // each lane takes the previous lane's register, lane 0 the input
         case (wid)
            dm_x9: begin
               next_x = {x_r[`DM_OPW-`DM_W9-1:0], operand_x[`DM_W9-1:0]};
               next_y = {y_r[`DM_OPW-`DM_W9-1:0], operand_y[`DM_W9-1:0]};
            end
            dm_x18: begin
               next_x = {x_r[`DM_OPW-`DM_W18-1:0], operand_x[`DM_W18-1:0]};
               next_y = {y_r[`DM_OPW-`DM_W18-1:0], operand_y[`DM_W18-1:0]};
            end
            default: begin
               next_x = operand_x;
               next_y = operand_y;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         x_r <= '0;
         y_r <= '0;
         sx_r <= 1'b0;
         sy_r <= 1'b0;
         sub_r <= 1'b0;
         v_r <= 1'b0;
      end else begin
         x_r <= next_x;
         y_r <= next_y;
         sx_r <= next_sx;
         sy_r <= next_sy;
         sub_r <= next_sub;
         v_r <= in_valid;
      end
   end

   // bypass passes the would-be register value straight on
   assign x1 = cfg[`DM_F_IN_REG] ? x_r : next_x;
   assign y1 = cfg[`DM_F_IN_REG] ? y_r : next_y;
   assign sx1 = cfg[`DM_F_IN_REG] ? sx_r : next_sx;
   assign sy1 = cfg[`DM_F_IN_REG] ? sy_r : next_sy;
   assign sub1 = cfg[`DM_F_IN_REG] ? sub_r : next_sub;
   assign v1 = cfg[`DM_F_IN_REG] ? v_r : in_valid;

   // ==========================================
   // stage 2: multipliers and pipeline register
   dm_lanes_t p_r, next_p, p2;
   logic sub2_r, v2_r, sub2, v2;

   always_comb begin
      next_p = '0;
      for (int i = 0; i < `DM_LANES; i++) begin
         if (i < dm_count(dm_plain_multiply_op, wid)) begin
            next_p[i] = dm_mul(x1 >> (i * wb), y1 >> (i * wb), wb, sx1, sy1);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         p_r <= '0;
         sub2_r <= 1'b0;
         v2_r <= 1'b0;
      end else begin
         p_r <= next_p;
         sub2_r <= sub1;
         v2_r <= v1;
      end
   end

   assign p2 = cfg[`DM_F_PIPE_REG] ? p_r : next_p;
   assign sub2 = cfg[`DM_F_PIPE_REG] ? sub2_r : sub1;
   assign v2 = cfg[`DM_F_PIPE_REG] ? v2_r : v1;

   // ==========================================
   // stage 3: adders, accumulators, output register
   logic [1:0][71:0] acc, next_acc;
   logic [143:0] o_r, next_o;
   logic ov_r;
   dm_lanes_t vals;

   always_comb begin
      logic [71:0] base, pair;
      base = '0;
      pair = '0;
      vals = '0;
      next_acc = clr ? '0 : acc;
      case (op)
         dm_multiply_accumulate_op: begin
            for (int e = 0; e < `DM_ACCS; e++) begin
               base = clr ? '0 : acc[e];
               vals[e] = sub2 ? base - p2[e] : base + p2[e];
               if (v2) begin
                  next_acc[e] = vals[e];
               end
            end
         end
         dm_dual_product_addsub_op: begin
            for (int e = 0; e < 4; e++) begin
               // first pair product on even lane, second pair on odd lane
               vals[e] = sub2 ? p2[2*e] - p2[2*e+1] : p2[2*e] + p2[2*e+1];
            end
         end
         dm_dual_product_addsub_accumulate_op: begin
            for (int e = 0; e < `DM_ACCS; e++) begin
               base = clr ? '0 : acc[e];
               pair = sub2 ? p2[2*e] - p2[2*e+1] : p2[2*e] + p2[2*e+1];
               vals[e] = base + pair;
               if (v2) begin
                  next_acc[e] = vals[e];
               end
            end
         end
         default: vals = p2;
      endcase
      next_o = dm_pack(vals, cnt);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc <= '0;
         o_r <= '0;
         ov_r <= 1'b0;
      end else begin
         acc <= next_acc;
         o_r <= next_o;
         ov_r <= v2;
      end
   end

   // ==========================================
   // result flops; output register adds one stage in front
   logic [143:0] next_res;
   logic next_rv;

   always_comb begin
      next_res = cfg[`DM_F_OUT_REG] ? o_r : next_o;
      next_rv = cfg[`DM_F_OUT_REG] ? ov_r : v2;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         result <= '0;
         result_valid <= 1'b0;
      end else begin
         result <= next_res;
         result_valid <= next_rv;
      end
   end
endmodule : dm_slice

//--- test/dm_slice_chk.sv
`timescale 1ns/100ps
module dm_slice_chk (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic in_valid,
   input wire logic [71:0] operand_x,
   input wire logic [71:0] operand_y,
   input wire logic sign_x,
   input wire logic sign_y,
   input wire logic sub_sel,
   input wire logic shift_load,
   input wire logic [143:0] result,
   input wire logic result_valid
);
   // ====
   // shadow state
   logic [11:0] cfg;
   logic [2:0] age;
   logic [3:0] hist;
   logic [3:0] cnt;
   logic [17:0] ps9;
   logic [35:0] pu18, padd, psub;
   logic [71:0] pu36;
   logic sgn, sb;
   wire [1:0] lat = {1'b0, cfg[4]} + cfg[5] + cfg[6];
   // age gate: old-config samples must drain from up to four stages
   wire st = age == 3'h7 && cfg[11:4] == 8'h00;
   wire dy = age == 3'h7 && cfg[7:4] == 4'h8;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= 12'h000;
         age <= 3'h0;
         hist <= 4'h0;
      end else begin
         if (reg_wr && reg_addr == 4'h0) begin
            cfg <= reg_wdata[11:0];
         end
         age <= (reg_wr && reg_addr == 4'h0) ? 3'h0 : age + (age != 3'h7);
         hist <= {hist[2:0], in_valid};
      end
   end
   always_ff @(posedge ref_clk) begin
      ps9 <= {{9{operand_x[8]}}, operand_x[8:0]} * {{9{operand_y[8]}}, operand_y[8:0]};
      pu18 <= operand_x[17:0] * operand_y[17:0];
      pu36 <= operand_x[35:0] * operand_y[35:0];
      padd <= operand_x[8:0] * operand_y[8:0] + operand_x[17:9] * operand_y[17:9];
      psub <= operand_x[8:0] * operand_y[8:0] - operand_x[17:9] * operand_y[17:9];
      sgn <= sign_x & sign_y & !shift_load;
      sb <= sub_sel & !sign_x & !sign_y & !shift_load;
   end
   always_comb begin
      case (cfg[1:0])
         2'h0: cnt = cfg[3] ? 4'h1 : cfg[2] ? 4'h4 : 4'h8;
         2'h1: cnt = cfg[3] ? 4'h1 : 4'h2;
         2'h2: cnt = cfg[3] ? 4'h1 : cfg[2] ? 4'h2 : 4'h4;
         default: cnt = (cfg[3] | cfg[2]) ? 4'h1 : 4'h2;
      endcase
   end
   // ====
   // properties
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_valid_latency:
   assert property (age == 3'h7 |-> result_valid == hist[lat]) else $error("valid latency");
   a_x18_product:
   assert property (st && cfg[3:0] == 4'h4 |-> result[35:0] == pu18) else $error("x18 mul");
   a_x36_product:
   assert property (st && cfg[3:0] == 4'h8 |-> result[71:0] == pu36) else $error("x36 mul");
   a_addsub_sum:
   assert property (st && cfg[3:0] == 4'h2 |-> result[35:0] == padd) else $error("pair sum");
   a_dyn_signed:
   assert property (dy && cfg[3:0] == 4'h0 && sgn |-> result[17:0] == ps9)
      else $error("signed product");
   a_dyn_subtract:
   assert property (dy && cfg[3:0] == 4'h2 && sb |-> result[35:0] == psub)
      else $error("pair difference");
   a_stat_count:
   assert property ($past(reg_rd) && $past(reg_addr) == 4'h8 && age == 3'h7
      |-> reg_rdata[7:4] == $past(cnt)) else $error("element count");
   a_ctrl_aligned:
   assert property (age == 3'h7 && cfg[7:0] == 8'h90 && $past(sgn)
      |-> result[17:0] == $past(ps9)) else $error("sign misaligned");
endmodule : dm_slice_chk
bind dm_slice dm_slice_chk i_dm_slice_chk (.*);

//--- test/dm_fabric.sv
`timescale 1ns/100ps
module dm_fabric (
   input wire logic ref_clk,
   output logic in_valid,
   output logic [71:0] operand_x,
   output logic [71:0] operand_y,
   output logic sign_x,
   output logic sign_y,
   output logic sub_sel,
   output logic shift_load
);
   initial begin
      {in_valid, operand_x, operand_y, sign_x, sign_y, sub_sel, shift_load} = '0;
   end
   // ====
   // one sample per edge; idle operands scramble so stale data never looks valid
   task automatic send(input logic v, input logic [71:0] x, input logic [71:0] y,
         input logic [3:0] c);
      @(posedge ref_clk);
      in_valid <= v;
      operand_x <= v ? x : ~operand_x;
      operand_y <= v ? y : ~operand_y;
      {sign_x, sign_y} <= c[3:2];
      sub_sel <= c[1];
      shift_load <= c[0];
   endtask : send
endmodule : dm_fabric

//--- test/tb.sv
`timescale 1ns/100ps
module tb;
   logic ref_clk, rst_n, reg_wr, reg_rd, in_valid, result_valid;
   logic sign_x, sign_y, sub_sel, shift_load;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [71:0] operand_x, operand_y;
   logic [143:0] result;
   int num_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   localparam logic [47:0] cnt_tbl = 48'h112124122148;
   dm_slice i_dm_slice (.*);
   dm_fabric i_dm_fabric (.*);
   // ====
   // tasks
   task automatic check(input logic [143:0] seen, input logic [143:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      #1 check(reg_rdata, e);
   endtask : rd
   task automatic idle(input int n);
      repeat (n) i_dm_fabric.send(1'h0, 72'h0, 72'h0, 4'h0);
   endtask : idle
   task automatic print_verdict;
      $display("tests %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict
   initial begin
      ref_clk = 1'h0;
      forever #10 ref_clk = ~ref_clk;
   end
   // hang guard, well above the few hundred cycles needed
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         num_errors++;
         print_verdict();
      end
   end
   // ====
   // sequence
   initial begin
      {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'h1;
      wr(4'hC, 32'hFFFFFFFF);
      rd(4'h0, 32'h0);
      rd(4'hC, 32'h0);
      for (int o = 0; o < 4; o++) begin
         for (int w = 0; w < 3; w++) begin
            wr(4'h0, 32'({2'(w), 2'(o)}));
            for (int k = 0; k < 9; k++) begin
               i_dm_fabric.send(1'h1, {8{9'(k * 37 + o)}}, {8{9'(k * 11 + w + 3)}}, 4'h0);
            end
            idle(2);
            rd(4'h0, 32'({2'(w), 2'(o)}));
            rd(4'h8, 32'({cnt_tbl[4 * (o * 3 + w) +: 4], 4'h0}));
         end
      end
      for (int l = 1; l < 3; l++) begin
         wr(4'h0, l == 1 ? 32'h80 : 32'h90);
         idle(8);
         i_dm_fabric.send(1'h1, 72'h1FF, 72'h1FF, 4'hC);
         i_dm_fabric.send(1'h1, 72'h1FF, 72'h1FF, 4'h0);
         idle(l - 1);
         #1 check(result[17:0], 18'h1);
         idle(1);
         #1 check(result[17:0], 18'h3FC01);
      end
      wr(4'h0, 32'h82);
      idle(8);
      i_dm_fabric.send(1'h1, 72'h405, 72'h605, 4'h2);
      idle(1);
      #1 check(result[35:0], 36'h13);
      wr(4'h0, 32'h81);
      wr(4'h4, 32'h1);
      i_dm_fabric.send(1'h1, 72'h3, 72'h4, 4'h0);
      i_dm_fabric.send(1'h1, 72'h5, 72'h5, 4'h0);
      i_dm_fabric.send(1'h1, 72'h2, 72'h3, 4'h2);
      idle(1);
      #1 check(result, 144'h1F);
      wr(4'h0, 32'h83);
      wr(4'h4, 32'h1);
      i_dm_fabric.send(1'h1, 72'h403, 72'hA04, 4'h0);
      i_dm_fabric.send(1'h1, 72'h403, 72'hA04, 4'h2);
      idle(1);
      #1 check(result, 144'h18);
      wr(4'h0, 32'h90);
      idle(8);
      i_dm_fabric.send(1'h1, 72'h3, 72'h5, 4'h1);
      i_dm_fabric.send(1'h1, 72'h2, 72'h4, 4'h1);
      i_dm_fabric.send(1'h1, 72'hC01, 72'hE01, 4'h0);
      idle(1);
      #1 check(result[35:0], {18'hF, 18'h8});
      idle(1);
      #1 check(result[35:0], {18'h2A, 18'h1});
      wr(4'h0, 32'h70);
      idle(8);
      i_dm_fabric.send(1'h1, 72'h7, 72'h6, 4'h0);
      for (int k = 0; k < 4; k++) begin
         idle(1);
         #1 check(result_valid, k == 3);
      end
      check(result[17:0], 18'h2A);
      print_verdict();
   end
endmodule : tb
